// ==== src/irq_unit_pkg.sv ====
// constants shared by the three source interrupt unit
package irq_unit_pkg;
  localparam logic [7:0] INTERRUPT_CONTROL_ADDR     = 8'h0b;
  localparam logic [7:0] INTERRUPT_CONTROL_RESET    = 8'h00;
  localparam logic [7:0] INTERRUPT_CONTROL_WR_MASK  = 8'h7f;
  localparam int         BIT_GIE       = 0;
  localparam int         BIT_EN_LO     = 1;
  localparam int         BIT_FLAG_LO   = 4;
  localparam int         NUM_SRC       = 3;
  localparam logic [7:0] VEC_EXT       = 8'h04;
  localparam logic [7:0] VEC_TIMER     = 8'h08;
  localparam logic [7:0] VEC_CONV      = 8'h0c;
endpackage : irq_unit_pkg

// ==== src/fall_edge_detect.sv ====
// falling edge detector for the active-low external request pin
`timescale 1ns/1ps
`default_nettype none
module fall_edge_detect (
  input  wire logic clk_sys,  // system clock
  input  wire logic rst_n,    // async reset, active low
  input  wire logic pin_n,    // sampled pin level
  output var  logic fall      // one-cycle pulse on high to low
);
  logic prev_r;

  // reset to low so no level seen at release counts as an edge;
  // a pin held low through reset must rise and fall again
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= pin_n;
    end
  end

  assign fall = prev_r & ~pin_n;
endmodule : fall_edge_detect
`default_nettype wire

// ==== src/three_source_interrupt_unit.sv ====
// interrupt control register, priority and vector request for three sources
`timescale 1ns/1ps
`default_nettype none
module three_source_interrupt_unit (
  input  wire logic       clk_sys,               // system clock
  input  wire logic       rst_n,                 // async reset, active low
  input  wire logic       second_clock_phase,    // phase strobe, acks here
  input  wire logic       ext_irq_n,             // external request pin
  input  wire logic       timer_overflow,        // timer overflow pulse
  input  wire logic       conv_done,             // conversion end pulse
  input  wire logic       stack_full,            // return stack is full
  input  wire logic       return_from_interrupt, // return-from-irq pulse
  input  wire logic       subroutine_return,     // plain return pulse
  input  wire logic [7:0] reg_addr,              // register address
  input  wire logic       reg_wr,                // register write strobe
  input  wire logic [7:0] reg_wdata,             // register write data
  input  wire logic       reg_rd,                // register read strobe
  output var  logic [7:0] reg_rdata,             // register read data
  output var  logic       irq_call,              // push pc and branch pulse
  output var  logic [7:0] irq_vector,            // branch target
  output var  logic       wake_up                // power-down wake request
);
  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] rdata_r;
  logic       call_r;
  logic [7:0] vec_r;
  logic       wake_r;
  logic       ext_fall;

  fall_edge_detect u_fall (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pin_n   (ext_irq_n),
    .fall    (ext_fall)
  );

  // ---------------------------------------------------------------
  // decode and priority
  // ---------------------------------------------------------------
  wire       hit_wr  = reg_wr & (reg_addr == irq_unit_pkg::INTERRUPT_CONTROL_ADDR);
  wire       hit_rd  = reg_rd & (reg_addr == irq_unit_pkg::INTERRUPT_CONTROL_ADDR);
  wire       gie     = ctrl_r[irq_unit_pkg::BIT_GIE];
  wire [2:0] enables =
    ctrl_r[irq_unit_pkg::BIT_EN_LO +: irq_unit_pkg::NUM_SRC];
  wire [2:0] flags   =
    ctrl_r[irq_unit_pkg::BIT_FLAG_LO +: irq_unit_pkg::NUM_SRC];
  wire [2:0] events  =
    {conv_done, timer_overflow, ext_fall};
  wire [2:0] pending = flags & enables;
  // acknowledge only on the phase strobe, held off by full stack
  wire       take    = second_clock_phase & gie & (|pending)
                       & ~stack_full;
  // fixed priority, lowest bit wins
  wire [2:0] grant   = pending & ~(pending - 3'b001);
  wire [7:0] vec_sel = grant[0] ? irq_unit_pkg::VEC_EXT :
                       grant[1] ? irq_unit_pkg::VEC_TIMER :
                                  irq_unit_pkg::VEC_CONV;
  // any enabled source raises wake-up, even with global enable low
  wire       wake    = |(events & enables);

  // ---------------------------------------------------------------
  // next control value
  // ---------------------------------------------------------------
  // software write first; hardware sets win over a clear in the same cycle
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (hit_wr) begin
      ctrl_nxt = reg_wdata & irq_unit_pkg::INTERRUPT_CONTROL_WR_MASK;
    end
    if (take) begin
      ctrl_nxt[irq_unit_pkg::BIT_GIE] = 1'b0;
      ctrl_nxt[irq_unit_pkg::BIT_FLAG_LO +: irq_unit_pkg::NUM_SRC] =
        ctrl_nxt[irq_unit_pkg::BIT_FLAG_LO +: irq_unit_pkg::NUM_SRC]
        & ~grant;
    end
    if (return_from_interrupt) begin
      ctrl_nxt[irq_unit_pkg::BIT_GIE] = 1'b1;
    end
    // subroutine_return deliberately leaves the enable alone
    ctrl_nxt[irq_unit_pkg::BIT_FLAG_LO +: irq_unit_pkg::NUM_SRC] =
      ctrl_nxt[irq_unit_pkg::BIT_FLAG_LO +: irq_unit_pkg::NUM_SRC]
      | events;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= irq_unit_pkg::INTERRUPT_CONTROL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // only the return address is pushed by the core on this pulse
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      call_r  <= 1'b0;
      vec_r   <= irq_unit_pkg::VEC_EXT;
      wake_r  <= 1'b0;
      rdata_r <= irq_unit_pkg::INTERRUPT_CONTROL_RESET;
    end else begin
      call_r  <= take;
      vec_r   <= take ? vec_sel : vec_r;
      wake_r  <= wake;
      rdata_r <= hit_rd ? ctrl_r : rdata_r;
    end
  end

  assign reg_rdata  = rdata_r;
  assign irq_call   = call_r;
  assign irq_vector = vec_r;
  assign wake_up    = wake_r;
endmodule : three_source_interrupt_unit
`default_nettype wire

// ==== dv/irq_unit_assertions.sv ====
// assertion checker on the interrupt unit ports
`timescale 1ns/1ps
`default_nettype none
module irq_unit_assertions (input wire logic clk_sys, rst_n, reg_rd, wake_up,
  input wire logic second_clock_phase, ext_irq_n, timer_overflow, conv_done,
  input wire logic stack_full, return_from_interrupt, irq_call,
  input wire logic [7:0] reg_rdata, irq_vector);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_call_gap: assert property (
    irq_call && !$past(return_from_interrupt) |=> !irq_call) else $error("gap");
  a_stack_block: assert property (
    stack_full |=> !irq_call) else $error("stack");
  a_phase_only: assert property (
    !second_clock_phase |=> !irq_call) else $error("phase");
  a_vec_legal: assert property (
    irq_call |-> irq_vector inside {8'h04, 8'h08, 8'h0c}) else $error("vec");
  a_vec_hold: assert property (
    !irq_call |-> $stable(irq_vector)) else $error("vec hold");
  a_wake_src: assert property (
    wake_up |-> $past(timer_overflow || conv_done) ||
    ($past(ext_irq_n, 2) && !$past(ext_irq_n))) else $error("wake");
  a_bit7_zero: assert property (!reg_rdata[7]) else $error("bit7");
  a_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata)) else $error("rdata");
endmodule : irq_unit_assertions
bind three_source_interrupt_unit irq_unit_assertions chk (.*);
`default_nettype wire

// ==== dv/core_model.sv ====
// core model: return stack depth, full after DEPTH open calls
`timescale 1ns/1ps
`default_nettype none
module core_model #(parameter int DEPTH = 2) (input wire logic clk_sys, rst_n,
  input wire logic push, pop, output var logic stack_full);
  logic [3:0] depth_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) depth_r <= 4'h0;
    else depth_r <= depth_r + 4'(push) - 4'(pop);
  end
  assign stack_full = (depth_r == 4'(DEPTH));
endmodule : core_model
`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench for the three source interrupt unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys = 0, rst_n = 0, second_clock_phase = 0, ext_irq_n = 1;
  logic reg_wr = 0, reg_rd = 0, irq_call, wake_up, stack_full;
  logic [3:0] pls = 4'h0;
  logic [7:0] reg_addr = 8'h0b, reg_wdata = 8'h00, reg_rdata, irq_vector;
  wire return_from_interrupt, subroutine_return, timer_overflow, conv_done;
  assign {return_from_interrupt, subroutine_return} = pls[3:2];
  assign {timer_overflow, conv_done} = pls[1:0];
  int fail_count = 0, checks_done = 0;
  three_source_interrupt_unit dut (.*);
  core_model core (.clk_sys, .rst_n, .push(irq_call), .stack_full,
    .pop(return_from_interrupt | subroutine_return));
  initial forever #2.5 clk_sys = ~clk_sys;
  task automatic chk(input logic [7:0] got, exp);
    checks_done++;
    fail_count += (got !== exp);
    if (got !== exp) $display("unexpected %0t %h %h", $time, got, exp);
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(negedge clk_sys) {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(negedge clk_sys) {reg_wr, reg_rd} = 2'b00;
    if (!w) chk(reg_rdata, d);
  endtask : acc
  task automatic ev(input logic [3:0] s, input logic [7:0] v);
    @(negedge clk_sys) {second_clock_phase, pls} = {1'b1, s};
    @(negedge clk_sys) pls = 4'h0;
    for (int i = 0; i < 8 && irq_call !== 1'b1 && v != 0; i++) @(negedge clk_sys);
    if (v != 0) chk(irq_vector | {7'h00, irq_call !== 1'b1}, v);
  endtask : ev
  task automatic t_pri();
    acc(1, 8'h0b, 8'h0f);
    @(negedge clk_sys) {ext_irq_n, pls} = 5'b00011;
    @(negedge clk_sys) pls = 4'h0;
    chk({7'h00, wake_up}, 8'h01);
    acc(1, 8'h0c, 8'h00);
    acc(0, 8'h0b, 8'h7f);
    ev(4'h0, 8'h04);
    acc(0, 8'h0b, 8'h6e);
    ev(4'h8, 8'h08);
    ev(4'h8, 8'h0c);
  endtask : t_pri
  task automatic t_stack();
    for (int k = 0; k < 2; k++) begin
      acc(1, 8'h0b, 8'h05);
      ev(4'h2, k == 0 ? 8'h08 : 8'h00);
    end
    repeat (6) @(negedge clk_sys) chk({7'h00, irq_call}, 8'h00);
    acc(0, 8'h0b, 8'h25);
    ev(4'h4, 8'h08);
    ev(4'h4, 8'h00);
    acc(0, 8'h0b, 8'h04);
  endtask : t_stack
  task automatic stop_test(input int late);
    fail_count += late;
    $display("checks %0d fails %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (5) @(negedge clk_sys);
    rst_n = 1;
    acc(0, 8'h0b, 8'h00);
    t_pri();
    t_stack();
    stop_test(0);
  end
  initial #20000 stop_test(1);
endmodule : tb
`default_nettype wire
